// [logic/tkd_diag_flags.sv]
// module: diagnostic status flags with apb access and masked interrupt
// Summary of operation
// - lost-token timeout sets own reconfiguration flag
// - token doubly addressed to us, answered, sets duplicate
// - on line, every token received sets duplicate
// - diagnostic read clears duplicate flag
// - receive line high sets activity flag
// - foreign token seen sets token flag
// - nak count reaching 128 or 4 sets flag
// - only clear-flags command clears excessive nak
// - diagnostic read keeps excessive nak
// - irq when nak or successor flag masked on
// - answered token matching tentative id sets flag
// - next-identifier update sets successor changed
// - only next-identifier read clears successor changed
// - bit 0 reserved, reads zero
// - 656 us idle line sets reconfig flag
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tkd_diag_flags #(
  parameter int IDLE_CYCLES = tkd_pkg::IDLE_CYCLES
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // network events from the protocol engine
  input  wire logic        receive_input,
  input  wire logic        lost_token_timeout,
  input  wire logic        token_seen,
  input  wire logic        token_from_self,
  input  wire logic        token_response,
  input  wire logic        token_received,
  input  wire logic [7:0]  destination_identifier,
  input  wire logic [7:0]  destination_identifier_2,
  input  wire logic        trailing_zeros_ok,
  input  wire logic        on_line,
  input  wire logic        fbe_nak,
  input  wire logic        next_id_update,
  input  wire logic [7:0]  next_id_value,
  // interrupt
  output logic             irq
);
  // receive line is asynchronous: two stages before use
  logic       rx_meta_q, rx_sync_q;
  logic [7:0] diag_q, diag_d;
  logic [2:0] ist_q, ist_d, imask_q, imask_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] next_id_q, next_id_d, tent_q, tent_d, node_q, node_d;
  logic [7:0] nak_q, nak_d;
  logic [16:0] idle_q, idle_d;
  logic [31:0] prdata_d;
  logic       wr, rd, rd_diag, rd_next, clr_cmd, idle_hit, nak_hit;
  logic       dup_ev, tent_ev;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign rd_diag = rd & (paddr == tkd_pkg::DIAG_OFS);
  assign rd_next = rd & (paddr == tkd_pkg::NEXT_ID_OFS);
  assign clr_cmd = wr & (paddr == tkd_pkg::CTRL_OFS) & pwdata[tkd_pkg::CTRL_CLR_BIT];
  assign irq     = |(ist_q & imask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else begin
      rx_meta_q <= receive_input;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_comb begin
    idle_hit = 1'b0;
    idle_d   = idle_q;
    if (rx_sync_q) begin
      idle_d = '0;
    end else if (idle_q == 17'(IDLE_CYCLES - 1)) begin
      idle_hit = 1'b1;
      idle_d   = '0;
    end else begin
      idle_d = idle_q + 17'h00001;
    end
  end

  always_comb begin
    nak_hit = 1'b0;
    nak_d   = nak_q;
    // >= keeps a threshold lowered mid-count from being skipped past
    if (fbe_nak) begin
      if (nak_q + 8'h01 >= (ctrl_q[tkd_pkg::CTRL_NAK4_BIT] ? tkd_pkg::NAK_SHORT
                                                           : tkd_pkg::NAK_LONG)) begin
        nak_hit = 1'b1;
        nak_d   = 8'h00;
      end else begin
        nak_d = nak_q + 8'h01;
      end
    end
  end

  always_comb begin
    dup_ev  = (token_response & (destination_identifier == node_q) &
               (destination_identifier_2 == node_q) & trailing_zeros_ok) |
              (on_line & token_received);
    tent_ev = token_response & (destination_identifier == tent_q);
    diag_d  = diag_q;
    if (rd_diag) diag_d[tkd_pkg::DUP_ID_BIT] = 1'b0;
    if (clr_cmd) diag_d[tkd_pkg::EXC_NAK_BIT] = 1'b0;
    if (rd_next) diag_d[tkd_pkg::SUCC_CHG_BIT] = 1'b0;
    // sets come last so an event in the clearing cycle is kept
    if (lost_token_timeout) diag_d[tkd_pkg::OWN_RECONFIG_FLAG_BIT] = 1'b1;
    if (dup_ev) diag_d[tkd_pkg::DUP_ID_BIT] = 1'b1;
    if (rx_sync_q) diag_d[tkd_pkg::RX_ACT_BIT] = 1'b1;
    if (token_seen & ~token_from_self) diag_d[tkd_pkg::TOKEN_BIT] = 1'b1;
    if (nak_hit) diag_d[tkd_pkg::EXC_NAK_BIT] = 1'b1;
    if (tent_ev) diag_d[tkd_pkg::TENT_BIT] = 1'b1;
    if (next_id_update) diag_d[tkd_pkg::SUCC_CHG_BIT] = 1'b1;
    diag_d[0] = 1'b0;
    next_id_d = next_id_update ? next_id_value : next_id_q;
    ctrl_d  = ctrl_q;
    imask_d = imask_q;
    tent_d  = tent_q;
    node_d  = node_q;
    ist_d   = ist_q;
    if (wr && paddr == tkd_pkg::IRQ_STAT_OFS) ist_d = ist_q & ~pwdata[2:0];
    if (wr && paddr == tkd_pkg::IRQ_MASK_OFS) imask_d = pwdata[2:0];
    if (wr && paddr == tkd_pkg::CTRL_OFS) ctrl_d = {1'b0, pwdata[tkd_pkg::CTRL_NAK4_BIT]};
    if (wr && paddr == tkd_pkg::TENT_ID_OFS) tent_d = pwdata[7:0];
    if (wr && paddr == tkd_pkg::NODE_ID_OFS) node_d = pwdata[7:0];
    if (clr_cmd) ist_d[tkd_pkg::IRQ_RECONFIG_FLAG_BIT] = 1'b0;
    if (idle_hit) ist_d[tkd_pkg::IRQ_RECONFIG_FLAG_BIT] = 1'b1;
    // flag-backed bits follow their flag: a one written here cannot hide a set flag
    ist_d[tkd_pkg::IRQ_NAK_BIT]  = diag_d[tkd_pkg::EXC_NAK_BIT];
    ist_d[tkd_pkg::IRQ_SUCC_BIT] = diag_d[tkd_pkg::SUCC_CHG_BIT];
    prdata_d = 32'h00000000;
    case (paddr)
      tkd_pkg::DIAG_OFS:     prdata_d = {24'h000000, diag_q};
      tkd_pkg::IRQ_STAT_OFS: prdata_d = {29'h00000000, ist_q};
      tkd_pkg::IRQ_MASK_OFS: prdata_d = {29'h00000000, imask_q};
      tkd_pkg::CTRL_OFS:     prdata_d = {30'h00000000, ctrl_q};
      tkd_pkg::NEXT_ID_OFS:  prdata_d = {24'h000000, next_id_q};
      tkd_pkg::TENT_ID_OFS:  prdata_d = {24'h000000, tent_q};
      tkd_pkg::NODE_ID_OFS:  prdata_d = {24'h000000, node_q};
      default:               prdata_d = 32'h00000000;
    endcase
  end

  // read data is registered in the setup cycle so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_q    <= tkd_pkg::DIAG_RST;
      ist_q     <= tkd_pkg::IRQ_RST;
      imask_q   <= tkd_pkg::IRQ_RST;
      ctrl_q    <= 2'h0;
      next_id_q <= tkd_pkg::ID_RST;
      tent_q    <= tkd_pkg::ID_RST;
      node_q    <= tkd_pkg::ID_RST;
      nak_q     <= 8'h00;
      idle_q    <= 17'h00000;
      prdata    <= 32'h00000000;
    end else begin
      diag_q    <= diag_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      ctrl_q    <= ctrl_d;
      next_id_q <= next_id_d;
      tent_q    <= tent_d;
      node_q    <= node_d;
      nak_q     <= nak_d;
      idle_q    <= idle_d;
      if (psel && !penable) prdata <= prdata_d;
    end
  end

  property p_irq_mask;
    @(posedge pclk) disable iff (!presetn)
      (diag_q[tkd_pkg::EXC_NAK_BIT] && imask_q[tkd_pkg::IRQ_NAK_BIT]) |-> irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq not raised");

  property p_nak_keep;
    @(posedge pclk) disable iff (!presetn)
      (rd_diag && diag_q[tkd_pkg::EXC_NAK_BIT] && !clr_cmd) |=> diag_q[tkd_pkg::EXC_NAK_BIT];
  endproperty
  a_nak_keep: assert property (p_nak_keep) else $error("nak flag lost on read");

  property p_dup_clr;
    @(posedge pclk) disable iff (!presetn)
      (rd_diag && !dup_ev) |=> !diag_q[tkd_pkg::DUP_ID_BIT];
  endproperty
  a_dup_clr: assert property (p_dup_clr) else $error("dup flag not cleared");

  property p_succ_set;
    @(posedge pclk) disable iff (!presetn)
      next_id_update |=> diag_q[tkd_pkg::SUCC_CHG_BIT] && ist_q[tkd_pkg::IRQ_SUCC_BIT];
  endproperty
  a_succ_set: assert property (p_succ_set) else $error("successor flag not set");

  property p_succ_keep;
    @(posedge pclk) disable iff (!presetn)
      (diag_q[tkd_pkg::SUCC_CHG_BIT] && !rd_next) |=> diag_q[tkd_pkg::SUCC_CHG_BIT];
  endproperty
  a_succ_keep: assert property (p_succ_keep) else $error("successor flag dropped");

  property p_own_reconfig_flag;
    @(posedge pclk) disable iff (!presetn)
      lost_token_timeout |=> diag_q[tkd_pkg::OWN_RECONFIG_FLAG_BIT] [*2];
  endproperty
  a_own_reconfig_flag: assert property (p_own_reconfig_flag) else $error("own reconfig not sticky");

  property p_rx_act;
    @(posedge pclk) disable iff (!presetn)
      $rose(rx_sync_q) |=> diag_q[tkd_pkg::RX_ACT_BIT];
  endproperty
  a_rx_act: assert property (p_rx_act) else $error("activity flag not set");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      !diag_q[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_token_keep;
    @(posedge pclk) disable iff (!presetn)
      diag_q[tkd_pkg::TOKEN_BIT] |=> diag_q[tkd_pkg::TOKEN_BIT];
  endproperty
  a_token_keep: assert property (p_token_keep) else $error("token flag dropped");

  property p_rx_keep;
    @(posedge pclk) disable iff (!presetn)
      diag_q[tkd_pkg::RX_ACT_BIT] |=> diag_q[tkd_pkg::RX_ACT_BIT];
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("activity flag dropped");

  // the flag checks below restate each rule from the pins; the nak and idle checks start from nak_hit, nak_q, idle_hit and rx_sync_q
  property p_dup_set;
    @(posedge pclk) disable iff (!presetn)
      (token_response && destination_identifier == node_q &&
       destination_identifier_2 == node_q && trailing_zeros_ok) |=> diag_q[tkd_pkg::DUP_ID_BIT];
  endproperty
  a_dup_set: assert property (p_dup_set) else $error("duplicate id not flagged");

  property p_dup_online;
    @(posedge pclk) disable iff (!presetn)
      (on_line && token_received) |=> diag_q[tkd_pkg::DUP_ID_BIT];
  endproperty
  a_dup_online: assert property (p_dup_online) else $error("token on line not flagged");

  property p_token_set;
    @(posedge pclk) disable iff (!presetn)
      (token_seen && !token_from_self) |=> diag_q[tkd_pkg::TOKEN_BIT];
  endproperty
  a_token_set: assert property (p_token_set) else $error("foreign token not flagged");

  property p_tent_set;
    @(posedge pclk) disable iff (!presetn)
      (token_response && destination_identifier == tent_q) |=> diag_q[tkd_pkg::TENT_BIT];
  endproperty
  a_tent_set: assert property (p_tent_set) else $error("tentative match not flagged");

  property p_nak_set;
    @(posedge pclk) disable iff (!presetn)
      nak_hit |=> diag_q[tkd_pkg::EXC_NAK_BIT] && ist_q[tkd_pkg::IRQ_NAK_BIT];
  endproperty
  a_nak_set: assert property (p_nak_set) else $error("excessive nak not flagged");

  // the counter restarts at each hit, so it never reaches the long threshold
  property p_nak_range;
    @(posedge pclk) disable iff (!presetn)
      nak_q < tkd_pkg::NAK_LONG;
  endproperty
  a_nak_range: assert property (p_nak_range) else $error("nak count out of range");

  property p_nak_clr;
    @(posedge pclk) disable iff (!presetn)
      (clr_cmd && !nak_hit) |=> !diag_q[tkd_pkg::EXC_NAK_BIT];
  endproperty
  a_nak_clr: assert property (p_nak_clr) else $error("excessive nak not cleared");

  property p_irq_succ;
    @(posedge pclk) disable iff (!presetn)
      (diag_q[tkd_pkg::SUCC_CHG_BIT] && imask_q[tkd_pkg::IRQ_SUCC_BIT]) |-> irq;
  endproperty
  a_irq_succ: assert property (p_irq_succ) else $error("irq not raised for successor");

  property p_idle_set;
    @(posedge pclk) disable iff (!presetn)
      idle_hit |=> ist_q[tkd_pkg::IRQ_RECONFIG_FLAG_BIT];
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("reconfig not flagged");

  property p_idle_rst;
    @(posedge pclk) disable iff (!presetn)
      rx_sync_q |=> idle_q == 17'h00000;
  endproperty
  a_idle_rst: assert property (p_idle_rst) else $error("idle timer not restarted");
endmodule : tkd_diag_flags
`default_nettype wire

// [logic/tkd_pkg.sv]
// package: register map, bit positions, reset values and timing counts for diagnostic flags
`default_nettype none
package tkd_pkg;
  // register byte addresses
  localparam logic [11:0] DIAG_OFS      = 12'h000;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h008;
  localparam logic [11:0] CTRL_OFS      = 12'h00C;
  localparam logic [11:0] NEXT_ID_OFS   = 12'h010;
  localparam logic [11:0] TENT_ID_OFS   = 12'h014;
  localparam logic [11:0] NODE_ID_OFS   = 12'h018;
  // diagnostic flag bit positions
  localparam int OWN_RECONFIG_FLAG_BIT  = 7;
  localparam int DUP_ID_BIT     = 6;
  localparam int RX_ACT_BIT     = 5;
  localparam int TOKEN_BIT      = 4;
  localparam int EXC_NAK_BIT    = 3;
  localparam int TENT_BIT       = 2;
  localparam int SUCC_CHG_BIT   = 1;
  // interrupt status bit positions
  localparam int IRQ_NAK_BIT    = 0;
  localparam int IRQ_SUCC_BIT   = 1;
  localparam int IRQ_RECONFIG_FLAG_BIT  = 2;
  // control register fields
  localparam int CTRL_NAK4_BIT  = 0;
  localparam int CTRL_CLR_BIT   = 1;
  // reset values
  localparam logic [7:0] DIAG_RST    = 8'h00;
  localparam logic [2:0] IRQ_RST     = 3'h0;
  localparam logic [7:0] ID_RST      = 8'h00;
  // nak thresholds
  localparam logic [7:0] NAK_LONG    = 8'h80;
  localparam logic [7:0] NAK_SHORT   = 8'h04;
  // line idle time
  localparam int CLK_MHZ        = 100;
  localparam int IDLE_US        = 656;
  localparam int IDLE_CYCLES    = IDLE_US * CLK_MHZ;
endpackage : tkd_pkg
`default_nettype wire

// [tb/tb.sv]
// testbench for the diagnostic status flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, ed;
  logic [7:0]  node, tent, nv;
  logic        sev;
  int          err_total, n_checks, cyc;
  logic        net_rx, net_self, net_zok, net_online;
  logic [5:0]  net_ev;
  logic [7:0]  net_id1, net_id2, net_nid;
  tkd_net_model i_net (.clk(pclk), .rx(net_rx), .ev(net_ev), .self_tok(net_self), .id1(net_id1),
                       .id2(net_id2), .zok(net_zok), .online(net_online), .nid(net_nid));
  tkd_diag_flags #(.IDLE_CYCLES(50)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_input(net_rx),
    .lost_token_timeout(net_ev[0]), .token_seen(net_ev[1]), .token_from_self(net_self),
    .token_response(net_ev[2]), .token_received(net_ev[3]),
    .destination_identifier(net_id1), .destination_identifier_2(net_id2),
    .trailing_zeros_ok(net_zok), .on_line(net_online), .fbe_nak(net_ev[4]),
    .next_id_update(net_ev[5]), .next_id_value(net_nid), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  // request held until pready is sampled high; released only after that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    sev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), e, rdv);
    chk("pslverr", 32'h0, {31'h0, sev});
  endtask : rd
  task automatic chki(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : chki
  function automatic int nak_n(input logic s);
    return s ? 4 : 128;
  endfunction : nak_n
  initial begin
    {psel, penable, pwrite, paddr, pwdata, err_total, n_checks, cyc} = '0;
    presetn = 1'b0;
    void'($urandom(32'h8A908C6D));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    node = 8'($urandom_range(1, 254));
    tent = ~node;
    nv = 8'($urandom);
    rd(tkd_pkg::DIAG_OFS, 32'h0);
    chki(1'b0);
    apb(1'b1, tkd_pkg::NODE_ID_OFS, {24'h0, node});
    apb(1'b1, tkd_pkg::TENT_ID_OFS, {24'h0, tent});
    rd(tkd_pkg::NODE_ID_OFS, {24'h0, node});
    rd(tkd_pkg::TENT_ID_OFS, {24'h0, tent});
    i_net.pulse(2, node, ~node, 1'b1);
    i_net.pulse(2, node, node, 1'b0);
    rd(tkd_pkg::DIAG_OFS, 32'h0);
    i_net.pulse(2, node, node, 1'b1);
    rd(tkd_pkg::DIAG_OFS, 32'h40);
    rd(tkd_pkg::DIAG_OFS, 32'h0);
    i_net.online <= 1'b1;
    i_net.pulse(3);
    rd(tkd_pkg::DIAG_OFS, 32'h40);
    i_net.online <= 1'b0;
    i_net.pulse(2, tent, 8'($urandom), 1'b0);
    ed = 32'h04;
    rd(tkd_pkg::DIAG_OFS, ed);
    $display("identifier tests done");
    i_net.pulse(0);
    i_net.self_tok <= 1'b1;
    i_net.pulse(1);
    ed = 32'h84;
    rd(tkd_pkg::DIAG_OFS, ed);
    i_net.self_tok <= 1'b0;
    i_net.pulse(1);
    i_net.rx <= 1'b1;
    repeat (4) @(posedge pclk);
    ed = 32'hB4;
    rd(tkd_pkg::DIAG_OFS, ed);
    rd(tkd_pkg::DIAG_OFS, ed);
    $display("line and token tests done");
    apb(1'b1, tkd_pkg::IRQ_MASK_OFS, 32'h1);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, tkd_pkg::CTRL_OFS, 32'(s));
      repeat (nak_n(s[0]) - 1) i_net.pulse(4);
      rd(tkd_pkg::DIAG_OFS, ed);
      chki(1'b0);
      i_net.pulse(4);
      rd(tkd_pkg::DIAG_OFS, ed | 32'h08);
      rd(tkd_pkg::DIAG_OFS, ed | 32'h08);
      chki(1'b1);
      apb(1'b1, tkd_pkg::IRQ_STAT_OFS, 32'h1);
      chki(1'b1);
      apb(1'b1, tkd_pkg::CTRL_OFS, 32'(s) | 32'h2);
      rd(tkd_pkg::DIAG_OFS, ed);
      rd(tkd_pkg::CTRL_OFS, 32'(s));
      chki(1'b0);
    end
    $display("nak tests done");
    apb(1'b1, tkd_pkg::IRQ_MASK_OFS, 32'h2);
    i_net.pulse(5, nv);
    ed = ed | 32'h02;
    rd(tkd_pkg::DIAG_OFS, ed);
    rd(tkd_pkg::DIAG_OFS, ed);
    chki(1'b1);
    rd(tkd_pkg::NEXT_ID_OFS, {24'h0, nv});
    ed = ed & ~32'h02;
    chki(1'b0);
    rd(tkd_pkg::DIAG_OFS, ed);
    $display("successor tests done");
    apb(1'b1, tkd_pkg::IRQ_STAT_OFS, 32'h7);
    apb(1'b1, tkd_pkg::IRQ_MASK_OFS, 32'h4);
    rd(tkd_pkg::IRQ_MASK_OFS, 32'h4);
    i_net.rx <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(tkd_pkg::IRQ_STAT_OFS, 32'h0);
    repeat (60) @(posedge pclk);
    rd(tkd_pkg::IRQ_STAT_OFS, 32'h4);
    chki(1'b1);
    rd(12'h0FC, 32'h0);
    apb(1'b1, tkd_pkg::DIAG_OFS, 32'hFF);
    rd(tkd_pkg::DIAG_OFS, ed);
    $display("idle and map tests done");
    conclude();
  end
endmodule : tb
`default_nettype wire

// [tb/tkd_net_model.sv]
// network-side model: line level and protocol event pulses with their qualifiers
`timescale 1ns/1ps
`default_nettype none
module tkd_net_model (
  // clock
  input  wire logic       clk,
  // line and events
  output logic            rx,
  output logic [5:0]      ev,
  output logic            self_tok,
  output logic [7:0]      id1,
  output logic [7:0]      id2,
  output logic            zok,
  output logic            online,
  output logic [7:0]      nid
);
  initial begin
    rx = 1'b0;
    ev = 6'h00;
    self_tok = 1'b0;
    id1 = 8'h00;
    id2 = 8'h00;
    zok = 1'b0;
    online = 1'b0;
    nid = 8'h00;
  end
  // one-cycle event; ids and zeros flag qualify it only during the pulse
  task automatic pulse(input int k, input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00,
                       input logic z = 1'b0);
    @(posedge clk);
    ev <= 6'h01 << k;
    id1 <= a;
    id2 <= b;
    nid <= a;
    zok <= z;
    @(posedge clk);
    ev <= 6'h00;
    // stale id1, id2 and zok are scrambled so nothing can lean on them; nid keeps its value
    id1 <= ~a;
    id2 <= ~b;
    zok <= ~z;
  endtask : pulse
endmodule : tkd_net_model
`default_nettype wire
